//--- fault_status_pkg.sv
// Package: field layout, offsets and codes of the data fault status register
`default_nettype none
package fault_status_pkg;
    localparam logic [11:0] off_status_lo  = 12'h000;
    localparam logic [11:0] off_status_hi  = 12'h004;
    localparam logic [63:0] reset_status   = 64'h0;
    localparam int          bit_ue         = 31;
    localparam int          bit_bus_error_flag       = 30;
    localparam int          bit_bus_timeout_flag       = 29;
    localparam int          bit_mhit_hi    = 27;
    localparam int          bit_mhit_lo    = 26;
    localparam int          bit_nc         = 25;
    localparam int          bit_nf         = 24;
    localparam int          pos_asi        = 16;
    localparam int          bit_tm         = 15;
    localparam int          pos_ft         = 7;
    localparam int          bit_se         = 6;
    localparam int          pos_ctx        = 4;
    localparam int          bit_pr         = 3;
    localparam int          bit_w          = 2;
    localparam int          bit_ow         = 1;
    localparam int          bit_fv         = 0;
    localparam logic [7:0]  asi_tl0_big    = 8'h80;
    localparam logic [7:0]  asi_tl0_little = 8'h88;
    localparam logic [7:0]  asi_tlx_big    = 8'h04;
    localparam logic [7:0]  asi_tlx_little = 8'h0c;
    localparam logic [7:0]  asi_se_a       = 8'h15;
    localparam logic [7:0]  asi_se_b       = 8'h1d;
    localparam logic [6:0]  ft_priv        = 7'h01;
    localparam logic [6:0]  ft_nf_se       = 7'h02;
    localparam logic [6:0]  ft_noncache    = 7'h04;
    localparam logic [6:0]  ft_invalid     = 7'h08;
    localparam logic [1:0]  ctx_primary    = 2'h0;
    localparam logic [1:0]  ctx_secondary  = 2'h1;
    localparam logic [1:0]  ctx_nucleus    = 2'h2;
    localparam logic [1:0]  ctx_none       = 2'h3;
    localparam logic [1:0]  ctx_shared     = 2'h3;
    typedef enum logic [1:0] {
        kind_miss       = 2'h0,
        kind_exception  = 2'h1,
        kind_error      = 2'h3,
        kind_protection = 2'h2
    } fault_kind_t;
endpackage : fault_status_pkg
`default_nettype wire

//--- fault_enc_if.sv
// Interface: attributes in, encoded fields out, between capture and encoder
`timescale 1ns/1ps
`default_nettype none
interface fault_enc_if;
    logic       asi_explicit;
    logic [7:0] asi_in;
    logic       trap_level_nonzero;
    logic       little_endian_select;
    logic       privileged_state;
    logic       as_if_user_asi;
    logic       te_privileged;
    logic       te_side_effect;
    logic       te_cacheable;
    logic       nonfaulting_load;
    logic       atomic_or_simd;
    logic       invalid_asi;
    logic       invalid_va;
    logic       bad_access_type;
    logic       asi_translating;
    logic [1:0] ctx_req;
    logic [1:0] ctx_effective;
    logic [7:0] asi_out;
    logic [6:0] fault_type;
    logic [1:0] context_select;
    logic       side_effect;
    modport capture (output asi_explicit, asi_in, trap_level_nonzero, little_endian_select,
                     privileged_state, as_if_user_asi, te_privileged, te_side_effect,
                     te_cacheable, nonfaulting_load, atomic_or_simd, invalid_asi,
                     invalid_va, bad_access_type, asi_translating, ctx_req, ctx_effective,
                     input asi_out, fault_type, context_select, side_effect);
    modport encoder (input asi_explicit, asi_in, trap_level_nonzero, little_endian_select,
                     privileged_state, as_if_user_asi, te_privileged, te_side_effect,
                     te_cacheable, nonfaulting_load, atomic_or_simd, invalid_asi,
                     invalid_va, bad_access_type, asi_translating, ctx_req, ctx_effective,
                     output asi_out, fault_type, context_select, side_effect);
endinterface : fault_enc_if
`default_nettype wire

//--- fault_encode.sv
// Combinational encoder for fault type, implicit identifier and context
`timescale 1ns/1ps
`default_nettype none
module fault_encode (
    fault_enc_if.encoder e
);
    import fault_status_pkg::*;

    logic [6:0] ft;

    always_comb begin
        ft = 7'h00;
        if (e.invalid_asi || e.invalid_va || e.bad_access_type) begin
            // Entry not looked up, other bits meaningless
            ft = ft_invalid;
        end else begin
            if (e.te_privileged && (!e.privileged_state || e.as_if_user_asi)) begin
                ft = ft | ft_priv;
            end
            if (e.nonfaulting_load && e.te_side_effect) begin
                ft = ft | ft_nf_se;
            end
            if (e.atomic_or_simd && !e.te_cacheable) begin
                ft = ft | ft_noncache;
            end
        end
    end

    always_comb begin
        if (e.asi_explicit) begin
            e.asi_out = e.asi_in;
        end else if (!e.trap_level_nonzero) begin
            e.asi_out = e.little_endian_select ? asi_tl0_little : asi_tl0_big;
        end else begin
            e.asi_out = e.little_endian_select ? asi_tlx_little : asi_tlx_big;
        end
    end

    always_comb begin
        if (!e.asi_translating || e.invalid_asi) begin
            e.context_select = ctx_none;
        end else if (e.ctx_req == ctx_shared) begin
            // Shared context has no code of its own
            e.context_select = e.ctx_effective;
        end else begin
            e.context_select = e.ctx_req;
        end
    end

    assign e.fault_type  = ft;
    assign e.side_effect = e.te_side_effect || (e.asi_out == asi_se_a)
                           || (e.asi_out == asi_se_b);
endmodule : fault_encode
`default_nettype wire

//--- data_fault_status_capture.sv
// Data MMU fault status capture with APB register access
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module data_fault_status_capture (
    input  wire  logic                          clk,
    input  wire  logic                          arst_n,
    // APB slave
    input  wire  logic                          psel,
    input  wire  logic                          penable,
    input  wire  logic                          pwrite,
    input  wire  logic [11:0]                   paddr,
    input  wire  logic [31:0]                   pwdata,
    input  wire  logic [3:0]                    pstrb,
    output var   logic [31:0]                   prdata,
    output var   logic                          pready,
    output var   logic                          pslverr,
    // Fault report from load/store pipeline
    input  wire  logic                          fault_report,
    input  wire  fault_status_pkg::fault_kind_t fault_kind,
    input  wire  logic                          asi_explicit,
    input  wire  logic [7:0]                    asi_in,
    input  wire  logic [2:0]                    trap_level,
    input  wire  logic                          little_endian_select,
    input  wire  logic                          privileged_state,
    input  wire  logic                          as_if_user_asi,
    input  wire  logic                          te_privileged,
    input  wire  logic                          te_side_effect,
    input  wire  logic                          te_cacheable,
    input  wire  logic                          nonfaulting_load,
    input  wire  logic                          atomic_or_simd,
    input  wire  logic                          store_access,
    input  wire  logic                          invalid_asi,
    input  wire  logic                          invalid_va,
    input  wire  logic                          bad_access_type,
    input  wire  logic                          asi_translating,
    input  wire  logic [1:0]                    ctx_req,
    input  wire  logic [1:0]                    ctx_effective,
    input  wire  logic                          uncorrectable_err,
    input  wire  logic                          bus_err,
    input  wire  logic                          bus_timeout,
    input  wire  logic                          tlb_multihit,
    input  wire  logic                          noncacheable_space,
    // Status seen by trap logic
    output var   logic                          fault_valid,
    output var   logic                          overwrite_bit
);
    import fault_status_pkg::*;

    logic        rst_meta;
    logic        rst_n;
    logic [31:0] status_lo;
    logic [31:0] status_hi;
    logic [31:0] next_lo;
    logic [31:0] next_hi;
    logic [31:0] wr_lo;
    logic [31:0] wr_hi;
    logic        apb_done;
    logic        apb_wr;
    logic        hit_lo;
    logic        hit_hi;
    logic        is_miss;
    logic        is_error;
    logic        is_exc;
    logic        fv_now;

    fault_enc_if enc ();

    fault_encode u_encode (
        .e (enc.encoder)
    );

    // Reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign enc.asi_explicit         = asi_explicit;
    assign enc.asi_in               = asi_in;
    assign enc.trap_level_nonzero   = (trap_level != 3'h0);
    assign enc.little_endian_select = little_endian_select;
    assign enc.privileged_state     = privileged_state;
    assign enc.as_if_user_asi       = as_if_user_asi;
    assign enc.te_privileged        = te_privileged;
    assign enc.te_side_effect       = te_side_effect;
    assign enc.te_cacheable         = te_cacheable;
    assign enc.nonfaulting_load     = nonfaulting_load;
    assign enc.atomic_or_simd       = atomic_or_simd;
    assign enc.invalid_asi          = invalid_asi;
    assign enc.invalid_va           = invalid_va;
    assign enc.bad_access_type      = bad_access_type;
    assign enc.asi_translating      = asi_translating;
    assign enc.ctx_req              = ctx_req;
    assign enc.ctx_effective        = ctx_effective;

    // APB decode; access completes on the second access cycle
    assign apb_done = psel && penable && pready;
    assign apb_wr   = apb_done && pwrite && !pslverr;
    assign hit_lo   = (paddr == off_status_lo);
    assign hit_hi   = (paddr == off_status_hi);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !(hit_lo || hit_hi);
            if (psel && penable && !pready && !pwrite) begin
                prdata <= hit_lo ? status_lo : (hit_hi ? status_hi : 32'h0);
            end
        end
    end

    // Software write with byte strobes
    always_comb begin
        wr_lo = status_lo;
        wr_hi = status_hi;
        for (int b = 0; b < 4; b++) begin
            if (apb_wr && hit_lo && pstrb[b]) begin
                wr_lo[b*8 +: 8] = pwdata[b*8 +: 8];
            end
            if (apb_wr && hit_hi && pstrb[b]) begin
                wr_hi[b*8 +: 8] = pwdata[b*8 +: 8];
            end
        end
    end

    assign is_miss  = (fault_kind == kind_miss);
    assign is_error = (fault_kind == kind_error);
    assign is_exc   = (fault_kind == kind_exception);
    assign fv_now   = status_lo[bit_fv];

    // Hardware capture applied on top of any software write, so a fault
    // arriving in the same cycle as a clear is never lost; a miss then sets only the miss flag, since fv_now is the old bit.
    always_comb begin
        next_lo = wr_lo;
        next_hi = wr_hi;
        if (fault_report) begin
            if (is_miss) begin
                next_lo[bit_tm] = 1'b1;
                if (!fv_now) begin
                    next_lo[bit_w]   = store_access;
                    next_lo[bit_pr]  = privileged_state;
                    next_lo[bit_nf]  = nonfaulting_load;
                    next_lo[pos_ctx +: 2] = enc.context_select;
                    next_lo[bit_ow]  = 1'b0;
                    next_lo[bit_fv]  = 1'b0;
                end
            end else begin
                next_lo[bit_fv]  = 1'b1;
                next_lo[bit_ow]  = fv_now;
                // Miss flag kept only if a miss was the last thing held
                next_lo[bit_tm]  = status_lo[bit_tm] && !fv_now;
                next_lo[bit_w]   = store_access;
                next_lo[bit_pr]  = privileged_state;
                next_lo[bit_nf]  = nonfaulting_load;
                next_lo[pos_ctx +: 2] = enc.context_select;
                next_lo[pos_asi +: 8] = enc.asi_out;
                if (is_exc) begin
                    next_lo[pos_ft +: 7] = enc.fault_type;
                end
                if (is_error) begin
                    next_lo[bit_ue]      = uncorrectable_err;
                    next_lo[bit_bus_error_flag]    = bus_err;
                    next_lo[bit_bus_timeout_flag]    = bus_timeout;
                    next_lo[bit_mhit_hi] = tlb_multihit;
                    next_lo[bit_nc]      = noncacheable_space;
                    next_lo[bit_se]      = enc.side_effect;
                end
            end
        end
        // Lower multihit bit and unused bits never hold a one
        next_lo[bit_mhit_lo] = 1'b0;
        next_lo[28]          = 1'b0;
        next_lo[14]          = 1'b0;
        next_hi              = 32'h0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_lo <= reset_status[31:0];
            status_hi <= reset_status[63:32];
        end else begin
            status_lo <= next_lo;
            status_hi <= next_hi;
        end
    end

    // Outputs from flops, loaded from next_lo on the same edge as the status register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_valid   <= 1'b0;
            overwrite_bit <= 1'b0;
        end else begin
            fault_valid   <= next_lo[bit_fv];
            overwrite_bit <= next_lo[bit_ow];
        end
    end
endmodule : data_fault_status_capture
`default_nettype wire

//--- fault_status_checker_assertions.sv
// Checker: port-level timing and status relations of the fault capture block
`timescale 1ns/1ps
`default_nettype none
module fault_status_checker (
    input wire logic                          clk,
    input wire logic                          arst_n,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [11:0]                   paddr,
    input wire logic [31:0]                   prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic                          fault_report,
    input wire fault_status_pkg::fault_kind_t fault_kind,
    input wire logic                          fault_valid,
    input wire logic                          overwrite_bit
);
    import fault_status_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic acc = psel && penable && pready;

    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing one cycle after access");
    a_ready_not_early: assert property (psel && !penable |=> !pready)
        else $error("pready during first access cycle");
    a_err_on_unmapped: assert property (acc |-> pslverr == !(paddr == off_status_lo
        || paddr == off_status_hi)) else $error("pslverr wrong for address");
    a_high_reads_zero: assert property (acc && !pwrite && paddr == off_status_hi
        |-> prdata == 32'h0) else $error("high word not zero");
    a_fv_on_exception: assert property (fault_report && fault_kind != kind_miss
        |=> fault_valid && overwrite_bit == $past(fault_valid))
        else $error("fault valid or overwrite wrong after exception");
    a_miss_keeps_fv: assert property (fault_report && fault_kind == kind_miss
        && !(acc && pwrite) |=> fault_valid == $past(fault_valid))
        else $error("miss changed fault valid");
    a_ow_implies_fv: assert property (fault_report && !(acc && pwrite)
        |=> !overwrite_bit || fault_valid) else $error("overwrite set without fault valid");
    a_quiet_holds_status: assert property (!fault_report && !(acc && pwrite)
        |=> $stable({fault_valid, overwrite_bit})) else $error("status moved with no cause");
    a_read_mirrors_bits: assert property (acc && !pwrite && paddr == off_status_lo
        && !$past(fault_report) |-> prdata[1:0] == {overwrite_bit, fault_valid})
        else $error("read data disagrees with status outputs");

    c_overwrite: cover property (fault_report && fault_kind != kind_miss && fault_valid);
    c_miss_clear: cover property (fault_report && fault_kind == kind_miss && !fault_valid);
    c_unmapped: cover property (acc && pslverr);
endmodule : fault_status_checker
`default_nettype wire

//--- lsu_fault_model.sv
// Load/store pipeline model: reports faulting accesses to the capture block
`timescale 1ns/1ps
`default_nettype none
module lsu_fault_model (
    input  wire logic                          clk,
    output var  logic                          fault_report,
    output var  fault_status_pkg::fault_kind_t fault_kind,
    output var  logic [33:0]                   attr
);
    import fault_status_pkg::*;
    initial begin
        fault_report = 1'b0;
        fault_kind = kind_miss;
        attr = 34'h0;
    end
    // Caller stands just after a rising edge; last low keeps the pulse up for a burst
    task automatic send(input fault_kind_t k, input logic [33:0] v, input logic last);
        fault_report <= 1'b1;
        fault_kind <= k;
        attr <= v;
        @(posedge clk);
        if (last) begin
            fault_report <= 1'b0;
            // Attributes mean nothing without the pulse, so never leave them valid
            attr <= ~v;
        end
    endtask : send
endmodule : lsu_fault_model
`default_nettype wire

//--- tb_data_fault_status_capture.sv
// Testbench: register access and fault capture of the data fault status block
`timescale 1ns/1ps
`default_nettype none
module tb_data_fault_status_capture;
    import fault_status_pkg::*;
    typedef struct packed {
        logic asi_explicit; logic [7:0] asi_in; logic [2:0] trap_level;
        logic little_endian_select, privileged_state, as_if_user_asi, te_privileged;
        logic te_side_effect, te_cacheable, nonfaulting_load, atomic_or_simd, store_access;
        logic invalid_asi, invalid_va, bad_access_type, asi_translating;
        logic [1:0] ctx_req, ctx_effective;
        logic uncorrectable_err, bus_err, bus_timeout, tlb_multihit, noncacheable_space;
    } attr_t;
    logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, seed = 32'h92a2, exp_st = 32'h0, prdata, rd, r;
    logic        pready, pslverr, fault_report, fault_valid, overwrite_bit, err;
    fault_kind_t fault_kind;
    attr_t       a, v;
    int          fail_count = 0, checks = 0, cycles = 0, n;

    always #10 clk = ~clk;

    data_fault_status_capture dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .fault_report, .fault_kind,
        .asi_explicit(a.asi_explicit), .asi_in(a.asi_in), .trap_level(a.trap_level),
        .little_endian_select(a.little_endian_select), .privileged_state(a.privileged_state),
        .as_if_user_asi(a.as_if_user_asi), .te_privileged(a.te_privileged),
        .te_side_effect(a.te_side_effect), .te_cacheable(a.te_cacheable),
        .nonfaulting_load(a.nonfaulting_load), .atomic_or_simd(a.atomic_or_simd),
        .store_access(a.store_access), .invalid_asi(a.invalid_asi), .invalid_va(a.invalid_va),
        .bad_access_type(a.bad_access_type), .asi_translating(a.asi_translating),
        .ctx_req(a.ctx_req), .ctx_effective(a.ctx_effective),
        .uncorrectable_err(a.uncorrectable_err), .bus_err(a.bus_err),
        .bus_timeout(a.bus_timeout), .tlb_multihit(a.tlb_multihit),
        .noncacheable_space(a.noncacheable_space), .fault_valid, .overwrite_bit);
    lsu_fault_model src (.clk, .fault_report, .fault_kind, .attr(a));

    task automatic tally_and_finish();
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            fail_count = fail_count + 1;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        checks = checks + 1;
        if (seen !== want) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    function automatic logic [31:0] rnd();
        seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
        return seed;
    endfunction : rnd

    function automatic attr_t rattr();
        logic [63:0] w;
        w = {rnd(), rnd()};
        return attr_t'(w[33:0]);
    endfunction : rattr

    function automatic logic [31:0] predict(input logic [31:0] o, input fault_kind_t k,
                                            input attr_t x);
        logic [31:0] s;
        logic [7:0]  asi;
        s = o;
        asi = x.asi_explicit ? x.asi_in : (x.trap_level == 3'h0) ?
            (x.little_endian_select ? asi_tl0_little : asi_tl0_big) :
            (x.little_endian_select ? asi_tlx_little : asi_tlx_big);
        if (k == kind_miss && o[bit_fv]) begin
            s[bit_tm] = 1'b1;
            return s;
        end
        s[bit_w] = x.store_access;
        s[bit_pr] = x.privileged_state;
        s[bit_nf] = x.nonfaulting_load;
        s[pos_ctx +: 2] = (!x.asi_translating || x.invalid_asi) ? ctx_none :
            (x.ctx_req == ctx_shared ? x.ctx_effective : x.ctx_req);
        s[bit_fv] = k != kind_miss;
        s[bit_ow] = k != kind_miss && o[bit_fv];
        s[bit_tm] = k == kind_miss || (o[bit_tm] && !o[bit_fv]);
        if (k == kind_miss) begin
            return s;
        end
        s[pos_asi +: 8] = asi;
        if (k == kind_exception) begin
            s[pos_ft +: 7] = (x.invalid_asi || x.invalid_va || x.bad_access_type) ?
                ft_invalid : {4'h0, x.atomic_or_simd && !x.te_cacheable,
                x.nonfaulting_load && x.te_side_effect,
                x.te_privileged && (!x.privileged_state || x.as_if_user_asi)};
        end
        if (k == kind_error) begin
            s[bit_ue] = x.uncorrectable_err;
            s[bit_bus_error_flag] = x.bus_err;
            s[bit_bus_timeout_flag] = x.bus_timeout;
            s[bit_mhit_hi] = x.tlb_multihit;
            s[bit_nc] = x.noncacheable_space;
            s[bit_se] = x.te_side_effect || asi == asi_se_a || asi == asi_se_b;
        end
        return s;
    endfunction : predict

    // Ends one edge after release so back-to-back calls never reassign psel in one step
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // No local limit: a slave that never answers runs into the bench timeout
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic fault(input fault_kind_t k, input attr_t x, input logic last);
        exp_st = predict(exp_st, k, x);
        src.send(k, x, last);
    endtask : fault

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, off_status_lo, 32'h0);
        check("reset low", rd, reset_status[31:0]);
        for (int i = 0; i < 6; i++) begin
            v = rattr();
            v.asi_explicit = i > 3;
            v.trap_level = i[1] ? 3'h5 : 3'h0;
            v.little_endian_select = i[0];
            v.asi_in = i[0] ? asi_se_b : asi_se_a;
            v.te_side_effect = 1'b0;
            fault(i > 3 ? kind_error : kind_exception, v, 1'b1);
            apb(1'b0, off_status_lo, 32'h0);
            check("asi", rd, exp_st);
        end
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            if (r[3:2] == 2'h0) begin
                apb(1'b1, off_status_lo, 32'h0);
                exp_st = 32'h0;
            end
            n = int'(r % 3);
            for (int j = 0; j <= n; j++) begin
                r = rnd();
                fault(fault_kind_t'(r[1:0]), rattr(), j == n);
            end
            apb(1'b0, off_status_lo, 32'h0);
            check("status", rd, exp_st);
            check("flags", {30'h0, overwrite_bit, fault_valid}, {30'h0, exp_st[1:0]});
        end
        r = rnd();
        apb(1'b1, off_status_lo, r);
        exp_st = r & 32'hebffbfff;
        apb(1'b0, off_status_lo, 32'h0);
        check("write back", rd, exp_st);
        apb(1'b1, off_status_hi, r);
        check("high write err", {31'h0, err}, 32'h0);
        apb(1'b0, off_status_hi, 32'h0);
        check("high word", rd, 32'h0);
        apb(1'b1, 12'h008, ~r);
        check("unmapped write err", {31'h0, err}, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        check("unmapped read err", {31'h0, err}, 32'h1);
        apb(1'b0, off_status_lo, 32'h0);
        check("after refusal", rd, exp_st);
        tally_and_finish();
    end
endmodule : tb_data_fault_status_capture

bind data_fault_status_capture fault_status_checker chk (.clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .fault_report, .fault_kind, .fault_valid,
    .overwrite_bit);
`default_nettype wire
